/* File: video_memory_mapper.sv */
// Video memory mapper: control locations, fetch addressing, color banks
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Screen matrix base comes from pointer bits 7..4, sixteen 1K steps.
// - After reset the screen matrix sits at 1024..2023, also for bitmaps.
// - Bank-select bits 1..0 pick one of four 16K banks; bank 0 after reset.
// - Matrix address adds bank number times 0x4000.
// - Color memory fixed at 55296..56295; cell n colored by entry n.
// - Port bit 0 picks the processor's color bank.
// - Port bit 1 picks the video color bank independently.
// - Second color bank and its selects work only in native mode.
// - Standard bitmap colors come from the matrix, character modes from color memory.
// - Multicolor bitmap draws from color memory, matrix and background 0.
// - Character ROM appears to the processor at 53248..57343 when mapped.
// - In native mode port bit 2 high hides the character set from video; low shows it.
// - Configuration 14 swaps I/O out for character ROM at 0xD000..0xDFFF.
// - ROM holds eight 512-byte sets in fixed order.
// - Compat mode shows ROM image at 0x1000..0x1FFF in banks 0 and 2; base 2 (0x1000) default.
// - Pointer bits 3..1 pick a 2K character base; bit 0 ignored.
// - Character address adds the 0x4000 per bank offset.
// - In bitmap mode pointer bit 3 puts the bitmap at 0x0000 or 0x2000.
module video_memory_mapper
    import video_map_pkg::*;
#(
    parameter int COLOR_W = 4,
    parameter int CELL_W = 10
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [15:0] cpuAddr,
    input wire logic cpuWrEn,
    input wire logic cpuRdEn,
    input wire logic [7:0] cpuWrData,
    input wire logic [7:0] memConfig,
    input wire logic nativeMode,
    input wire logic bitmapMode,
    input wire logic multicolorMode,
    input wire logic fetchReq,
    input wire fetch_kind_e fetchKind,
    input wire logic [12:0] fetchIndex,
    output logic [7:0] cpuRdData,
    output logic [COLOR_W-1:0] cpuColorData,
    output logic cpuCharRomSel,
    output logic [11:0] cpuCharRomAddr,
    output charset_e cpuCharSet,
    output logic cpuColorBank,
    output logic videoColorBank,
    output logic fetchValid,
    output logic [15:0] fetchAddr,
    output logic fetchCharRom,
    output logic [11:0] fetchRomAddr,
    output logic [COLOR_W-1:0] fetchColor,
    output color_src_e colorSource
);
    // ---------------------------------------------------------------
    // Control locations
    // ---------------------------------------------------------------
    logic [7:0] portReg;
    logic [7:0] pointerReg;
    logic [7:0] bankReg;
    logic ioVisible;
    logic colorHit;
    logic romHit;
    logic cpuBankSel;
    logic vidBankSel;
    logic [CELL_W-1:0] cpuCell;
    logic [15:0] colorOffset;
    logic [15:0] romOffset;
    color_src_e next_colorSource;
    logic [7:0] next_rdData;

    // Configuration 14 trades the I/O window for character ROM
    assign ioVisible = (memConfig != CFG_CHAR_ROM);
    assign colorHit = ioVisible && (cpuAddr >= COLOR_RAM_FIRST) && (cpuAddr <= COLOR_RAM_LAST);
    assign romHit = !ioVisible && (cpuAddr >= CHAR_ROM_FIRST) && (cpuAddr <= CHAR_ROM_LAST);
    assign colorOffset = cpuAddr - COLOR_RAM_FIRST;
    assign romOffset = cpuAddr - CHAR_ROM_FIRST;
    assign cpuCell = colorOffset[CELL_W-1:0];

    // Compat mode pins both selects to bank 0 whatever the port holds
    assign cpuBankSel = nativeMode && portReg[PORT_CPU_COLOR_BIT];
    assign vidBankSel = nativeMode && portReg[PORT_VID_COLOR_BIT];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            portReg <= PORT_RESET;
        end else if (cpuWrEn && cpuAddr == ADDR_PORT) begin
            portReg <= cpuWrData;
        end
    end

    // Whole byte is stored; the host preserves the other nibble itself
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pointerReg <= POINTER_RESET;
        end else if (cpuWrEn && ioVisible && cpuAddr == ADDR_POINTER) begin
            pointerReg <= cpuWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bankReg <= BANKSEL_RESET;
        end else if (cpuWrEn && ioVisible && cpuAddr == ADDR_BANKSEL) begin
            bankReg <= cpuWrData;
        end
    end

    // ---------------------------------------------------------------
    // Processor reads and ROM window
    // ---------------------------------------------------------------
    always_comb begin
        next_rdData = 8'h00;
        if (cpuAddr == ADDR_PORT) begin
            next_rdData = portReg;
        end else if (ioVisible && cpuAddr == ADDR_POINTER) begin
            next_rdData = pointerReg;
        end else if (ioVisible && cpuAddr == ADDR_BANKSEL) begin
            next_rdData = bankReg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cpuRdData <= 8'h00;
        end else if (cpuRdEn) begin
            cpuRdData <= next_rdData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cpuCharRomSel <= 1'b0;
            cpuCharRomAddr <= 12'h000;
            cpuCharSet <= SET_UPPER;
        end else begin
            cpuCharRomSel <= romHit && (cpuRdEn || cpuWrEn);
            cpuCharRomAddr <= romOffset[11:0];
            cpuCharSet <= charset_e'(romOffset[11:9]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cpuColorBank <= 1'b0;
            videoColorBank <= 1'b0;
        end else begin
            cpuColorBank <= cpuBankSel;
            videoColorBank <= vidBankSel;
        end
    end

    // ---------------------------------------------------------------
    // Video fetch path
    // ---------------------------------------------------------------
    fetch_if fx ();

    assign fx.kind = fetchKind;
    assign fx.index = fetchIndex;
    assign fx.bank = bankReg[1:0];
    assign fx.pointer = pointerReg;
    assign fx.native = nativeMode;
    assign fx.hide = portReg[PORT_HIDE_BIT];

    address_former u_former (
        .fx(fx)
    );

    always_comb begin
        if (bitmapMode && !multicolorMode) begin
            next_colorSource = COLOR_FROM_MATRIX;
        end else if (bitmapMode) begin
            next_colorSource = COLOR_FROM_THREE;
        end else begin
            next_colorSource = COLOR_FROM_RAM;
        end
    end

    // Registers are sampled at the request, so a write lands on the next fetch
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fetchValid <= 1'b0;
            fetchAddr <= 16'h0000;
            fetchCharRom <= 1'b0;
            fetchRomAddr <= 12'h000;
            colorSource <= COLOR_FROM_RAM;
        end else begin
            fetchValid <= fetchReq;
            if (fetchReq) begin
                fetchAddr <= fx.addr;
                fetchCharRom <= fx.charRom;
                fetchRomAddr <= fx.romAddr;
                colorSource <= next_colorSource;
            end
        end
    end

    // Cell n of the matrix reads color entry n in the same cycle as its address
    color_ram #(
        .DATA_W(COLOR_W),
        .IDX_W(CELL_W)
    ) u_color (
        .mclk(mclk),
        .cpuWr(cpuWrEn && colorHit),
        .cpuBank(cpuBankSel),
        .cpuIndex(cpuCell),
        .cpuWrData(cpuWrData[COLOR_W-1:0]),
        .cpuRdData(cpuColorData),
        .vidBank(vidBankSel),
        .vidIndex(fetchIndex[CELL_W-1:0]),
        .vidRdData(fetchColor)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence sPointerWrite;
        cpuWrEn && ioVisible && cpuAddr == ADDR_POINTER;
    endsequence

    sequence sMatrixFetch;
        fetchReq && fetchKind == FETCH_MATRIX;
    endsequence

    chk_reset_defaults: assert property (
        $rose(reset_n) |-> pointerReg[7:4] == 4'h1 && pointerReg[3:1] == 3'h2 && bankReg[1:0] == 2'b00)
        else $error("pointer or bank not at default after reset");

    chk_matrix_address: assert property (
        sMatrixFetch |=> fetchValid && fetchAddr == {$past(bankReg[1:0]), $past(pointerReg[7:4]),
            $past(fetchIndex[9:0])})
        else $error("matrix fetch address wrong");

    chk_bank_offset: assert property (
        sMatrixFetch ##0 (bankReg[1:0] == 2'b11) |=> fetchAddr >= 16'hc000)
        else $error("bank 3 offset missing");

    chk_char_address: assert property (
        fetchReq && fetchKind == FETCH_CHAR |=> fetchAddr[13:11] == $past(pointerReg[3:1])
            && fetchAddr[15:14] == $past(bankReg[1:0]))
        else $error("character fetch address wrong");

    chk_bitmap_half: assert property (
        fetchReq && fetchKind == FETCH_BITMAP |=> fetchAddr[13] == $past(pointerReg[3]))
        else $error("bitmap half select wrong");

    chk_pointer_next_fetch: assert property (
        sPointerWrite ##1 !cpuWrEn ##1 sMatrixFetch |=> fetchAddr[13:10] == $past(cpuWrData[7:4], 3))
        else $error("new pointer not used by next fetch");

    chk_compat_image: assert property (
        fetchReq && fetchKind == FETCH_CHAR && !nativeMode && bankReg[0]
            |=> !fetchCharRom)
        else $error("ROM image seen in odd bank in compat mode");

    chk_hide_charset: assert property (
        fetchReq && nativeMode && portReg[PORT_HIDE_BIT] |=> !fetchCharRom)
        else $error("character set visible while hidden");

    chk_color_banks: assert property (
        !nativeMode |=> !cpuColorBank && !videoColorBank)
        else $error("second color bank used in compat mode");

    chk_video_bank: assert property (
        nativeMode |=> videoColorBank == $past(portReg[PORT_VID_COLOR_BIT])
            && cpuColorBank == $past(portReg[PORT_CPU_COLOR_BIT]))
        else $error("color bank select does not follow port");

    chk_color_source: assert property (
        fetchReq && bitmapMode && multicolorMode |=> colorSource == COLOR_FROM_THREE)
        else $error("multicolor bitmap color source wrong");

    chk_rom_window: assert property (
        cpuRdEn && memConfig == CFG_CHAR_ROM && cpuAddr[15:12] == 4'hd |=> cpuCharRomSel
            && cpuCharRomAddr == $past(cpuAddr[11:0]))
        else $error("character ROM not mapped in configuration 14");

    chk_fetch_pulse: assert property (
        fetchValid == $past(fetchReq))
        else $error("fetch valid is not a one-cycle echo of the request");

    chk_bitmap_source: assert property (
        fetchReq && bitmapMode && !multicolorMode |=> colorSource == COLOR_FROM_MATRIX)
        else $error("standard bitmap color source wrong");

    chk_rom_set_order: assert property (
        romHit && cpuRdEn |=> cpuCharSet == $past(cpuAddr[11:9]))
        else $error("character set number wrong");

    chk_io_switched_out: assert property (
        cpuRdEn && !ioVisible && cpuAddr == ADDR_POINTER |=> cpuRdData == 8'h00)
        else $error("pointer register readable in configuration 14");

    chk_rom_sel_idle: assert property (
        !cpuRdEn && !cpuWrEn |=> !cpuCharRomSel)
        else $error("character ROM select without a processor cycle");
endmodule
`default_nettype wire

/* File: video_map_pkg.sv */
// Shared constants and types for the video memory mapper
package video_map_pkg;

    // ---------------------------------------------------------------
    // Register locations on the processor bus
    // ---------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT = 16'h0001;
    localparam logic [15:0] ADDR_POINTER = 16'hd018;
    localparam logic [15:0] ADDR_BANKSEL = 16'hdd00;

    // ---------------------------------------------------------------
    // Values after reset and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h14;
    localparam logic [7:0] BANKSEL_RESET = 8'h00;
    localparam int PORT_CPU_COLOR_BIT = 0;
    localparam int PORT_VID_COLOR_BIT = 1;
    localparam int PORT_HIDE_BIT = 2;
    localparam int POINTER_BITMAP_BIT = 3;

    // ---------------------------------------------------------------
    // Address windows
    // ---------------------------------------------------------------
    localparam logic [15:0] COLOR_RAM_FIRST = 16'hd800;
    localparam logic [15:0] COLOR_RAM_LAST = 16'hdbe7;
    localparam logic [15:0] CHAR_ROM_FIRST = 16'hd000;
    localparam logic [15:0] CHAR_ROM_LAST = 16'hdfff;
    localparam logic [13:0] ROM_IMAGE_FIRST = 14'h1000;
    localparam logic [13:0] ROM_IMAGE_LAST = 14'h1fff;
    localparam logic [15:0] BANK_STRIDE = 16'h4000;
    localparam logic [7:0] CFG_CHAR_ROM = 8'h0e;

    typedef enum logic [1:0] {
        FETCH_MATRIX = 2'b00,
        FETCH_CHAR = 2'b01,
        FETCH_BITMAP = 2'b10
    } fetch_kind_e;

    typedef enum logic [1:0] {
        COLOR_FROM_RAM = 2'b00,
        COLOR_FROM_MATRIX = 2'b01,
        COLOR_FROM_THREE = 2'b10
    } color_src_e;

    // Eight 512-byte sets in ROM order
    typedef enum logic [2:0] {
        SET_UPPER = 3'b000,
        SET_GRAPHICS = 3'b001,
        SET_REV_UPPER = 3'b010,
        SET_REV_GRAPHICS = 3'b011,
        SET_LOWER = 3'b100,
        SET_UPPER_GRAPHICS = 3'b101,
        SET_REV_LOWER = 3'b110,
        SET_REV_UPPER_GRAPHICS = 3'b111
    } charset_e;

endpackage

/* File: fetch_if.sv */
// Carrier between the mapper top and its address former
`timescale 1ns/1ps
`default_nettype none
interface fetch_if;
    import video_map_pkg::*;
    fetch_kind_e kind;
    logic [12:0] index;
    logic [1:0] bank;
    logic [7:0] pointer;
    logic native;
    logic hide;
    logic [15:0] addr;
    logic charRom;
    logic [11:0] romAddr;
    modport top (output kind, index, bank, pointer, native, hide, input addr, charRom, romAddr);
    modport former (input kind, index, bank, pointer, native, hide, output addr, charRom, romAddr);
endinterface
`default_nettype wire

/* File: address_former.sv */
// Video fetch address formation from bank and pointer fields
`timescale 1ns/1ps
`default_nettype none
module address_former
    import video_map_pkg::*;
(
    fetch_if.former fx
);
    logic [13:0] inBank;
    logic imageHere;

    always_comb begin
        case (fx.kind)
            FETCH_MATRIX: inBank = {fx.pointer[7:4], fx.index[9:0]};
            FETCH_CHAR: inBank = {fx.pointer[3:1], fx.index[10:0]};
            FETCH_BITMAP: inBank = {fx.pointer[POINTER_BITMAP_BIT], fx.index[12:0]};
            default: inBank = 14'h0000;
        endcase
    end

    // Bank offset added on top of the in-bank address
    assign fx.addr = 16'(fx.bank) * BANK_STRIDE + {2'b00, inBank};

    // Native: visible in every bank unless hidden; compat: banks 0 and 2 only
    always_comb begin
        imageHere = (fx.kind == FETCH_CHAR) && (inBank >= ROM_IMAGE_FIRST) && (inBank <= ROM_IMAGE_LAST);
        if (fx.native) begin
            fx.charRom = imageHere && !fx.hide;
        end else begin
            fx.charRom = imageHere && !fx.bank[0];
        end
    end

    assign fx.romAddr = inBank[11:0];
endmodule
`default_nettype wire

/* File: color_ram.sv */
// Two-bank color memory, processor port and video read port
`timescale 1ns/1ps
`default_nettype none
module color_ram #(
    parameter int DATA_W = 4,
    parameter int IDX_W = 10
) (
    input wire logic mclk,
    input wire logic cpuWr,
    input wire logic cpuBank,
    input wire logic [IDX_W-1:0] cpuIndex,
    input wire logic [DATA_W-1:0] cpuWrData,
    output logic [DATA_W-1:0] cpuRdData,
    input wire logic vidBank,
    input wire logic [IDX_W-1:0] vidIndex,
    output logic [DATA_W-1:0] vidRdData
);
    logic [DATA_W-1:0] mem [0:(2**(IDX_W+1))-1];

    always_ff @(posedge mclk) begin
        if (cpuWr) begin
            mem[{cpuBank, cpuIndex}] <= cpuWrData;
        end
        cpuRdData <= mem[{cpuBank, cpuIndex}];
    end

    always_ff @(posedge mclk) begin
        vidRdData <= mem[{vidBank, vidIndex}];
    end
endmodule
`default_nettype wire

/* File: video_host_model.sv */
// Host processor and video fetch model driving the mapper's near side
`timescale 1ns/1ps
`default_nettype none
module video_host_model
    import video_map_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] cpuRdData,
    output logic [15:0] cpuAddr,
    output logic cpuWrEn,
    output logic cpuRdEn,
    output logic [7:0] cpuWrData,
    output logic fetchReq,
    output fetch_kind_e fetchKind,
    output logic [12:0] fetchIndex
);
    initial begin
        cpuAddr = 16'h0000;
        cpuWrEn = 1'b0;
        cpuRdEn = 1'b0;
        cpuWrData = 8'h00;
        fetchReq = 1'b0;
        fetchKind = FETCH_MATRIX;
        fetchIndex = 13'h0000;
    end

    // ---------------------------------------------------------------
    // Processor cycles
    // ---------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpuAddr <= a;
        cpuWrData <= d;
        cpuWrEn <= 1'b1;
        @(posedge mclk);
        cpuWrEn <= 1'b0;
        // Released data must not look like the value just written
        cpuWrData <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        cpuAddr <= a;
        cpuRdEn <= 1'b1;
        @(posedge mclk);
        cpuRdEn <= 1'b0;
        #1;
        d = cpuRdData;
    endtask

    task automatic move_matrix(input logic [3:0] m);
        logic [7:0] p;
        rd(ADDR_POINTER, p);
        wr(ADDR_POINTER, (p & 8'h0f) | {m, 4'h0});
    endtask

    task automatic move_char(input logic [3:0] z);
        logic [7:0] p;
        rd(ADDR_POINTER, p);
        wr(ADDR_POINTER, (p & 8'hf0) | {4'h0, z});
    endtask

    // ---------------------------------------------------------------
    // Video fetch
    // ---------------------------------------------------------------
    task automatic fe(input fetch_kind_e k, input logic [12:0] i);
        @(posedge mclk);
        fetchReq <= 1'b1;
        fetchKind <= k;
        fetchIndex <= i;
        @(posedge mclk);
        fetchReq <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: video_memory_mapper_test.sv */
// Self-checking bench for the video memory mapper
`timescale 1ns/1ps
`default_nettype none
module video_memory_mapper_test;
    import video_map_pkg::*;

    logic mclk, reset_n, cpuWrEn, cpuRdEn, nativeMode, bitmapMode, multicolorMode, fetchReq;
    logic [15:0] cpuAddr, fetchAddr;
    logic [7:0] cpuWrData, memConfig, cpuRdData, d;
    logic [12:0] fetchIndex;
    fetch_kind_e fetchKind;
    logic [3:0] cpuColorData, fetchColor, m;
    logic cpuCharRomSel, cpuColorBank, videoColorBank, fetchValid, fetchCharRom;
    logic [11:0] cpuCharRomAddr, fetchRomAddr;
    charset_e cpuCharSet;
    color_src_e colorSource;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;

    video_memory_mapper i_video_memory_mapper (.mclk(mclk), .reset_n(reset_n), .cpuAddr(cpuAddr),
        .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuWrData(cpuWrData), .memConfig(memConfig),
        .nativeMode(nativeMode), .bitmapMode(bitmapMode), .multicolorMode(multicolorMode),
        .fetchReq(fetchReq), .fetchKind(fetchKind), .fetchIndex(fetchIndex), .cpuRdData(cpuRdData),
        .cpuColorData(cpuColorData), .cpuCharRomSel(cpuCharRomSel), .cpuCharRomAddr(cpuCharRomAddr),
        .cpuCharSet(cpuCharSet), .cpuColorBank(cpuColorBank), .videoColorBank(videoColorBank),
        .fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchCharRom(fetchCharRom),
        .fetchRomAddr(fetchRomAddr), .fetchColor(fetchColor), .colorSource(colorSource));

    video_host_model i_video_host_model (.mclk(mclk), .cpuRdData(cpuRdData), .cpuAddr(cpuAddr),
        .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuWrData(cpuWrData), .fetchReq(fetchReq),
        .fetchKind(fetchKind), .fetchIndex(fetchIndex));

    // ---------------------------------------------------------------
    // Clock, timeout and helpers
    // ---------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole sequence takes well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic mode(input logic n, input logic bm, input logic mc, input logic [7:0] cfg);
        @(posedge mclk);
        nativeMode <= n;
        bitmapMode <= bm;
        multicolorMode <= mc;
        memConfig <= cfg;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        memConfig = 8'h00;
        nativeMode = 1'b0;
        bitmapMode = 1'b0;
        multicolorMode = 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        i_video_host_model.rd(ADDR_POINTER, d);
        chk("pointer reset", 16'h0014, d);
        i_video_host_model.rd(ADDR_BANKSEL, d);
        chk("bank reset", 16'h0000, d);
        i_video_host_model.rd(16'h1234, d);
        chk("unmapped read", 16'h0000, d);
        i_video_host_model.fe(FETCH_MATRIX, 13'h0005);
        chk("fetch valid", 16'h0001, fetchValid);
        chk("default matrix", 16'h0405, fetchAddr);
        chk("char color src", COLOR_FROM_RAM, colorSource);
        i_video_host_model.fe(FETCH_CHAR, 13'h0000);
        chk("default char", 16'h1000, fetchAddr);
        chk("rom image bank0", 16'h0001, fetchCharRom);
        for (int b = 0; b < 4; b++) begin
            m = 4'(b * 4 + 3);
            i_video_host_model.wr(ADDR_BANKSEL, 8'(b));
            i_video_host_model.move_matrix(m);
            i_video_host_model.fe(FETCH_MATRIX, 13'h03e7);
            chk("matrix addr", {2'(b), m, 10'h3e7}, fetchAddr);
            i_video_host_model.rd(ADDR_POINTER, d);
            chk("char nibble kept", 16'h0004, d[3:0]);
        end
        for (int z = 0; z < 16; z++) begin
            i_video_host_model.move_char(4'(z));
            i_video_host_model.fe(FETCH_CHAR, 13'h07ff);
            chk("char addr", {2'd3, 3'(z >> 1), 11'h7ff}, fetchAddr);
            chk("no image bank3", 16'h0000, fetchCharRom);
        end
        i_video_host_model.rd(ADDR_POINTER, d);
        chk("matrix nibble kept", 16'h00ff, d);
        i_video_host_model.wr(ADDR_BANKSEL, 8'h02);
        i_video_host_model.move_char(4'h4);
        i_video_host_model.fe(FETCH_CHAR, 13'h0010);
        chk("bank2 char", 16'h9010, fetchAddr);
        chk("rom image bank2", 16'h0001, fetchCharRom);
        i_video_host_model.wr(ADDR_BANKSEL, 8'h01);
        for (int k = 0; k < 2; k++) begin
            mode(1'b0, 1'b1, 1'(k), 8'h00);
            i_video_host_model.move_char(4'(k * 8));
            i_video_host_model.fe(FETCH_BITMAP, 13'h1f3f);
            chk("bitmap addr", {2'd1, 1'(k), 13'h1f3f}, fetchAddr);
            chk("bitmap src", k ? COLOR_FROM_THREE : COLOR_FROM_MATRIX, colorSource);
        end
        mode(1'b0, 1'b0, 1'b1, 8'h00);
        i_video_host_model.fe(FETCH_MATRIX, 13'h0000);
        chk("mc char src", COLOR_FROM_RAM, colorSource);
        mode(1'b1, 1'b0, 1'b0, 8'h00);
        i_video_host_model.wr(ADDR_PORT, 8'h01);
        @(posedge mclk);
        #1;
        chk("cpu bank", 16'h0001, cpuColorBank);
        chk("video bank", 16'h0000, videoColorBank);
        i_video_host_model.wr(16'hd807, 8'h0a);
        i_video_host_model.wr(ADDR_PORT, 8'h00);
        i_video_host_model.wr(16'hd807, 8'h05);
        @(posedge mclk);
        #1;
        chk("cpu color b0", 16'h0005, cpuColorData);
        i_video_host_model.wr(ADDR_PORT, 8'h01);
        i_video_host_model.rd(16'hd807, d);
        chk("cpu color b1", 16'h000a, cpuColorData);
        i_video_host_model.wr(ADDR_PORT, 8'h02);
        i_video_host_model.fe(FETCH_MATRIX, 13'h0007);
        chk("video color b1", 16'h000a, fetchColor);
        i_video_host_model.wr(ADDR_PORT, 8'h00);
        i_video_host_model.fe(FETCH_MATRIX, 13'h0007);
        chk("video color b0", 16'h0005, fetchColor);
        mode(1'b0, 1'b0, 1'b0, 8'h00);
        i_video_host_model.wr(ADDR_PORT, 8'h03);
        i_video_host_model.fe(FETCH_MATRIX, 13'h0007);
        chk("compat cpu bank", 16'h0000, cpuColorBank);
        chk("compat video bank", 16'h0000, videoColorBank);
        chk("compat color", 16'h0005, fetchColor);
        mode(1'b1, 1'b0, 1'b0, 8'h00);
        i_video_host_model.move_char(4'h4);
        i_video_host_model.wr(ADDR_PORT, 8'h04);
        i_video_host_model.fe(FETCH_CHAR, 13'h0000);
        chk("hidden set", 16'h0000, fetchCharRom);
        i_video_host_model.wr(ADDR_PORT, 8'h00);
        i_video_host_model.fe(FETCH_CHAR, 13'h0123);
        chk("shown set", 16'h0001, fetchCharRom);
        chk("set addr bank1", 16'h5123, fetchAddr);
        chk("set rom addr", 16'h0123, fetchRomAddr);
        mode(1'b1, 1'b0, 1'b0, CFG_CHAR_ROM);
        for (int s = 0; s < 8; s++) begin
            i_video_host_model.rd(16'(16'hd000 + s * 512 + 5), d);
            chk("rom select", 16'h0001, cpuCharRomSel);
            chk("rom addr", 16'(s * 512 + 5), cpuCharRomAddr);
            chk("rom set", 16'(s), cpuCharSet);
        end
        i_video_host_model.rd(ADDR_POINTER, d);
        chk("io out", 16'h0000, d);
        close_out();
    end
endmodule
`default_nettype wire
